// [rtl/sdram_pkg.sv]
package sdram_pkg;

  // Clock period and precharge period, in nanoseconds.
  localparam int CLK_NS = 20;
  localparam int TRP_NS = 20;
  // Precharge cycles: a least time, so round up, and never below one cycle.
  localparam int TRP_RAW = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;
  localparam int TRP_W = 4;

  // Array geometry and pin widths.
  localparam int COL_W = 8;
  localparam int ROW_W = 11;
  localparam int DQ_W = 16;
  localparam int BANKS = 2;
  localparam int ADDR_W = 12;
  localparam int MODE_W = 10;

  // Address pin roles: bank select and the all-banks / auto-precharge bit.
  localparam int A_BANK = 11;
  localparam int A_AP = 10;

  // Mode word field positions.
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int WM_BIT = 9;

  // Mode field codes.
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  // Reset mode: latency two, burst of one, sequential, burst writes.
  localparam logic [MODE_W-1:0] MODE_RST = 10'h020;

  // Column wrap masks, one less than the burst length.
  localparam logic [COL_W-1:0] WRAP_ONE = 8'h00;
  localparam logic [COL_W-1:0] WRAP_TWO = 8'h01;
  localparam logic [COL_W-1:0] WRAP_FOUR = 8'h03;
  localparam logic [COL_W-1:0] WRAP_EIGHT = 8'h07;
  localparam logic [COL_W-1:0] WRAP_FULL = 8'hFF;
  localparam logic [COL_W-1:0] BEAT_ONE = 8'h01;

  // Command codes on {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  // Register bus layout.
  localparam int AV_AW = 4;
  localparam int AV_DW = 32;
  localparam logic [AV_AW-1:0] REG_MODE = 4'h0;
  localparam logic [AV_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AV_AW-1:0] REG_ROWS = 4'h8;
  localparam int ROWS_HI_LSB = 16;
  localparam int ST_ACT_LSB = 0;
  localparam int ST_PRE_LSB = 2;
  localparam int ST_BURST = 4;
  localparam int ST_WRITE = 5;

  typedef enum logic [1:0] {B_IDLE, B_ACTIVE, B_PRECH} bank_st_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } pin_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [1:0] be;
    logic [DQ_W-1:0] wdata;
  } arr_req_t;

endpackage

// [rtl/burst_col_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module burst_col_gen (
  input wire logic [sdram_pkg::COL_W-1:0] start_i, // Starting column.
  input wire logic [sdram_pkg::COL_W-1:0] beat_i, // Beat number in the burst.
  input wire logic [sdram_pkg::COL_W-1:0] wrap_i, // Burst length minus one.
  input wire logic interleave_i, // High for interleaved order.
  output logic [sdram_pkg::COL_W-1:0] col_o // Column of this beat.
);
  import sdram_pkg::*;

  logic [COL_W-1:0] low_seq;
  logic [COL_W-1:0] low_ilv;

  // Bits above the wrap mask stay fixed; the low bits add or XOR the beat.
  assign low_seq = COL_W'(start_i + beat_i);
  assign low_ilv = start_i ^ beat_i;
  assign col_o = (start_i & ~wrap_i) | ((interleave_i ? low_ilv : low_seq) & wrap_i);
endmodule
`default_nettype wire

// [rtl/sdram_burst_core.sv]
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_core #(
  parameter int TRP_CYCLES = sdram_pkg::TRP_CYC // Precharge period in cycles.
) (
  input wire logic MCLK_I, // System clock.
  input wire logic RST_I, // Synchronous reset, active high.
  input wire sdram_pkg::pin_cmd_t CMD_I, // Command strobes, active low.
  input wire logic [sdram_pkg::ADDR_W-1:0] ADDR_I, // Address pins.
  input wire logic [sdram_pkg::DQ_W-1:0] DQ_I, // Data pins, input side.
  output logic [sdram_pkg::DQ_W-1:0] DQ_O, // Data pins, output side.
  output logic [1:0] DQ_OE_O, // Per-byte output enable.
  input wire logic [1:0] BYTE_MASK_I, // Byte mask pair, bit 0 low byte.
  output sdram_pkg::arr_req_t ARR_REQ_O, // Request to the cell array.
  input wire logic [sdram_pkg::DQ_W-1:0] ARR_RDATA_I, // Array read data.
  input wire logic [sdram_pkg::AV_AW-1:0] AVS_ADDRESS_I, // Byte address.
  input wire logic AVS_READ_I, // Read request.
  input wire logic AVS_WRITE_I, // Write request.
  input wire logic [sdram_pkg::AV_DW-1:0] AVS_WRITEDATA_I, // Write data.
  output logic [sdram_pkg::AV_DW-1:0] AVS_READDATA_O, // Read data.
  output logic AVS_WAITREQUEST_O // Stall until the answer.
);
  import sdram_pkg::*;

  logic sel;
  logic [2:0] cmd_code;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_bst;
  logic is_mrs;
  logic is_rw;
  logic cmd_bank;
  logic [MODE_W-1:0] mode_q;
  logic [2:0] bl_code;
  logic fp;
  logic interleave;
  logic cl3;
  logic single_wr;
  logic [COL_W-1:0] wrap;
  logic burst_act_q;
  logic burst_wr_q;
  logic burst_bank_q;
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] beat_q;
  logic ap_q;
  logic ap_fire_q;
  logic ap_bank_q;
  logic stop_cmd;
  logic issue;
  logic cur_wr;
  logic cur_bank;
  logic cur_ap;
  logic [COL_W-1:0] cur_start;
  logic [COL_W-1:0] cur_beat;
  logic last;
  logic [COL_W-1:0] col;
  arr_req_t arr_q;
  bank_st_t bank_st_q [BANKS];
  logic [ROW_W-1:0] row_q [BANKS];
  logic [TRP_W-1:0] pre_cnt_q [BANKS];
  logic rd_v_q;
  logic [DQ_W-1:0] rd_d_q;
  logic out_v_q;
  logic [DQ_W-1:0] dq_q;
  logic [1:0] mask1_q;
  logic [1:0] mask2_q;
  logic av_req;
  logic ack_q;
  logic [AV_DW-1:0] rdata_q;

  // Command decode; chip select high is a deselect.
  assign sel = ~CMD_I.cs_n;
  assign cmd_code = {CMD_I.ras_n, CMD_I.cas_n, CMD_I.we_n};
  assign is_act = sel && (cmd_code == CMD_ACT);
  assign is_rd = sel && (cmd_code == CMD_RD);
  assign is_wr = sel && (cmd_code == CMD_WR);
  assign is_pre = sel && (cmd_code == CMD_PRE);
  assign is_bst = sel && (cmd_code == CMD_BST);
  assign is_mrs = sel && (cmd_code == CMD_MRS);
  assign is_rw = is_rd | is_wr;
  assign cmd_bank = ADDR_I[A_BANK];

  // Mode fields.
  assign bl_code = mode_q[BL_LSB +: 3];
  assign fp = (bl_code == BL_FULL);
  assign interleave = mode_q[BT_BIT] & ~fp;
  assign cl3 = (mode_q[CL_LSB +: 3] == CL_THREE);
  assign single_wr = mode_q[WM_BIT];

  // Wrap mask from the burst length; reserved codes act as a burst of one.
  always_comb begin
    unique case (bl_code)
      BL_TWO: wrap = WRAP_TWO;
      BL_FOUR: wrap = WRAP_FOUR;
      BL_EIGHT: wrap = WRAP_EIGHT;
      BL_FULL: wrap = WRAP_FULL;
      default: wrap = WRAP_ONE;
    endcase
  end

  // Mode word, loaded by the mode set command or by software.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      mode_q <= MODE_RST;
    end else if (is_mrs) begin
      mode_q <= ADDR_I[MODE_W-1:0];
    end else if (av_req && ack_q && AVS_WRITE_I && (AVS_ADDRESS_I == REG_MODE)) begin
      mode_q <= AVS_WRITEDATA_I[MODE_W-1:0];
    end
  end

  // A burst stop, or a precharge that reaches the bursting bank, ends the burst.
  assign stop_cmd = is_bst | (is_pre & (ADDR_I[A_AP] | (cmd_bank == burst_bank_q)));

  // The beat of this cycle: a new read or write replaces any burst in flight.
  assign issue = is_rw | (burst_act_q & ~stop_cmd);
  assign cur_wr = is_rw ? is_wr : burst_wr_q;
  assign cur_bank = is_rw ? cmd_bank : burst_bank_q;
  assign cur_start = is_rw ? ADDR_I[COL_W-1:0] : start_q;
  assign cur_beat = is_rw ? WRAP_ONE : beat_q;
  assign cur_ap = is_rw ? (ADDR_I[A_AP] & ~fp) : ap_q;

  // Full page never ends by itself; a single write ends after one beat.
  assign last = (~fp & (cur_beat == wrap)) | (cur_wr & single_wr);

  burst_col_gen u_col (
    .start_i(cur_start),
    .beat_i(cur_beat),
    .wrap_i(wrap),
    .interleave_i(interleave),
    .col_o(col)
  );

  // Burst sequencer: holds the start column and counts beats.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= 1'b0;
      start_q <= WRAP_ONE;
      beat_q <= WRAP_ONE;
      ap_q <= 1'b0;
    end else if (is_rw) begin
      burst_act_q <= ~last;
      burst_wr_q <= is_wr;
      burst_bank_q <= cmd_bank;
      start_q <= ADDR_I[COL_W-1:0];
      beat_q <= BEAT_ONE;
      ap_q <= ADDR_I[A_AP] & ~fp;
    end else if (stop_cmd) begin
      burst_act_q <= 1'b0;
    end else if (burst_act_q) begin
      beat_q <= COL_W'(beat_q + BEAT_ONE);
      if (last) begin
        burst_act_q <= 1'b0;
      end
    end
  end

  // Auto-precharge fires on the edge after the last beat is issued.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ap_fire_q <= 1'b0;
      ap_bank_q <= 1'b0;
    end else begin
      ap_fire_q <= issue & last & cur_ap;
      ap_bank_q <= cur_bank;
    end
  end

  // Array request: write data and byte masks taken in the same cycle.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      arr_q <= '0;
    end else begin
      arr_q.rd <= issue & ~cur_wr;
      arr_q.wr <= issue & cur_wr;
      arr_q.bank <= cur_bank;
      arr_q.row <= row_q[cur_bank];
      arr_q.col <= col;
      arr_q.be <= ~BYTE_MASK_I;
      arr_q.wdata <= DQ_I;
    end
  end
  assign ARR_REQ_O = arr_q;

  // Per-bank state, open row and precharge timer.
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic pre_hit;
    assign pre_hit = (is_pre && (ADDR_I[A_AP] || (cmd_bank == 1'(b))))
                     || (ap_fire_q && (ap_bank_q == 1'(b)));
    always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
        bank_st_q[b] <= B_IDLE;
        row_q[b] <= '0;
        pre_cnt_q[b] <= '0;
      end else begin
        unique case (bank_st_q[b])
          B_IDLE: begin
            if (is_act && (cmd_bank == 1'(b))) begin
              bank_st_q[b] <= B_ACTIVE;
              row_q[b] <= ADDR_I[ROW_W-1:0];
            end
          end
          B_ACTIVE: begin
            if (pre_hit) begin
              bank_st_q[b] <= B_PRECH;
              pre_cnt_q[b] <= TRP_W'(TRP_CYCLES - 1);
            end
          end
          B_PRECH: begin
            if (pre_cnt_q[b] == '0) begin
              bank_st_q[b] <= B_IDLE;
            end else begin
              pre_cnt_q[b] <= TRP_W'(pre_cnt_q[b] - 1'b1);
            end
          end
        endcase
      end
    end
  end

  // Read pipeline: array data lands one cycle after the request.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rd_v_q <= 1'b0;
      rd_d_q <= '0;
      out_v_q <= 1'b0;
      dq_q <= '0;
    end else begin
      rd_v_q <= arr_q.rd;
      rd_d_q <= ARR_RDATA_I;
      out_v_q <= cl3 ? rd_v_q : arr_q.rd;
      dq_q <= cl3 ? rd_d_q : ARR_RDATA_I;
    end
  end

  // Read byte masks act two clocks late, whatever the latency.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      mask1_q <= 2'h0;
      mask2_q <= 2'h0;
    end else begin
      mask1_q <= BYTE_MASK_I;
      mask2_q <= mask1_q;
    end
  end

  assign DQ_O = dq_q;
  assign DQ_OE_O = {2{out_v_q}} & ~mask2_q;

  // Register bus: one wait cycle, then the answer.
  assign av_req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = av_req & ~ack_q;
  assign AVS_READDATA_O = rdata_q;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= av_req & ~ack_q;
    end
  end

  // Read data is latched in the wait cycle; unmapped offsets read zero.
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_q <= '0;
    end else if (AVS_READ_I && !ack_q) begin
      rdata_q <= '0;
      unique case (AVS_ADDRESS_I)
        REG_MODE: rdata_q <= AV_DW'(mode_q);
        REG_STATUS: begin
          rdata_q[ST_ACT_LSB] <= (bank_st_q[0] == B_ACTIVE);
          rdata_q[ST_ACT_LSB + 1] <= (bank_st_q[1] == B_ACTIVE);
          rdata_q[ST_PRE_LSB] <= (bank_st_q[0] == B_PRECH);
          rdata_q[ST_PRE_LSB + 1] <= (bank_st_q[1] == B_PRECH);
          rdata_q[ST_BURST] <= burst_act_q;
          rdata_q[ST_WRITE] <= burst_wr_q;
        end
        REG_ROWS: begin
          rdata_q <= AV_DW'(row_q[0]) | (AV_DW'(row_q[1]) << ROWS_HI_LSB);
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  // Checks on the burst, mask and bank behaviour.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  AST_BANK_SEL: assert property (is_rw |=> arr_q.bank == $past(ADDR_I[A_BANK]))
    else $error("Array bank differs from address bit eleven.");
  AST_COL_LOW: assert property (is_rw |=> arr_q.col == $past(ADDR_I[COL_W-1:0]))
    else $error("First beat column is not the commanded column.");
  AST_WR_ZERO: assert property (is_wr |=> arr_q.wr && arr_q.wdata == $past(DQ_I))
    else $error("Write data not taken in the command cycle.");
  AST_WMASK: assert property (is_wr |=> arr_q.be == ~$past(BYTE_MASK_I))
    else $error("Write byte mask not applied in the same cycle.");
  AST_RD_CL2: assert property (is_rd && !cl3 |-> ##2 out_v_q)
    else $error("Read data not driven at latency two.");
  AST_RD_CL3: assert property (is_rd && cl3 |-> ##1 !is_mrs ##2 out_v_q)
    else $error("Read data not driven at latency three.");
  AST_RMASK: assert property (BYTE_MASK_I[0] |-> ##2 !DQ_OE_O[0])
    else $error("Low byte mask did not blank output two clocks later.");
  AST_FULL_PAGE: assert property (burst_act_q && fp && !is_rw && !stop_cmd
                                  |=> arr_q.col == COL_W'($past(arr_q.col) + BEAT_ONE))
    else $error("Full page burst did not step by one column.");
  AST_NO_AP_FULL: assert property (is_rw && fp |=> !ap_q)
    else $error("Auto-precharge armed in full page mode.");
  AST_PRE_ALL: assert property (is_pre && ADDR_I[A_AP] && bank_st_q[0] == B_ACTIVE
                                && bank_st_q[1] == B_ACTIVE
                                |=> bank_st_q[0] == B_PRECH && bank_st_q[1] == B_PRECH)
    else $error("Precharge all did not reach both banks.");
  AST_AP_START: assert property (ap_fire_q && bank_st_q[ap_bank_q] == B_ACTIVE
                                 |=> bank_st_q[$past(ap_bank_q)] == B_PRECH)
    else $error("Auto-precharge did not start.");
  AST_IDLE: assert property (bank_st_q[0] == B_PRECH && pre_cnt_q[0] == '0
                             |=> bank_st_q[0] == B_IDLE)
    else $error("Bank not idle after precharge period.");
  AST_SINGLE: assert property (is_wr && single_wr |=> !burst_act_q)
    else $error("Single write kept bursting.");
endmodule
`default_nettype wire

// [testbench/sdram_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Memory controller as seen from the device pins: one command per clock.
module sdram_ctrl_model (
  input wire logic clk_i, // System clock.
  output sdram_pkg::pin_cmd_t cmd_o, // Command strobes.
  output logic [11:0] addr_o, // Address pins.
  output logic [15:0] dq_o, // Data the controller drives.
  output logic [1:0] mask_o // Byte mask pair.
);
  import sdram_pkg::*;
  logic [1:0] open_q; // Banks opened by this controller.
  // Deselected from time zero, data parked on a pattern.
  initial begin
    cmd_o = 4'hF;
    addr_o = 12'h000;
    dq_o = 16'h5A5A;
    mask_o = 2'h0;
    open_q = 2'h0;
  end
  // One command cycle, driven just after a rising edge; op 7 is a no-op.
  task automatic put(input logic [2:0] op, input logic [11:0] a, input logic [15:0] d,
    input logic [1:0] m);
    @(posedge clk_i);
    cmd_o <= {1'b0, op};
    addr_o <= a;
    dq_o <= d;
    mask_o <= m;
  endtask
  // Column commands go only to a bank that this controller has opened.
  task automatic issue(input logic [2:0] op, input logic [11:0] a, input logic [15:0] d,
    input logic [1:0] m);
    if ((op == CMD_RD || op == CMD_WR) && !open_q[a[A_BANK]]) begin
      $display("model: column command to a closed bank dropped");
    end else begin
      put(op, a, d, m);
    end
    if (op == CMD_ACT) begin
      open_q[a[A_BANK]] = 1'b1;
    end
    if (op == CMD_PRE) begin
      open_q = a[A_AP] ? 2'h0 : (open_q & ~(2'h1 << a[A_BANK]));
    end
  endtask
  // Releases the data lines onto the inverse of dq_o as read at the call, before the update of a put in the same time step lands.
  task automatic rel();
    put(3'h7, 12'h000, ~dq_o, 2'h0);
  endtask
endmodule
`default_nettype wire

// [testbench/sdram_burst_column_access_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_column_access_bench;
  import sdram_pkg::*;
  localparam int TRP = 2;
  logic MCLK_I;
  logic RST_I;
  pin_cmd_t CMD_I;
  logic [11:0] ADDR_I;
  logic [15:0] DQ_I, DQ_O, ARR_RDATA_I, dq_m;
  logic [1:0] DQ_OE_O, BYTE_MASK_I;
  arr_req_t ARR_REQ_O;
  logic [3:0] AVS_ADDRESS_I;
  logic AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O, il, wm;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, rv;
  logic [11:0] aidx;
  logic [2:0] row [2];
  bit [15:0] mem [4096];
  bit [15:0] sh [4096];
  int n_fail, tests_run, bl, cl;
  sdram_burst_core #(.TRP_CYCLES(TRP)) sdram_burst_core_inst (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .CMD_I(CMD_I), .ADDR_I(ADDR_I), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O),
    .BYTE_MASK_I(BYTE_MASK_I), .ARR_REQ_O(ARR_REQ_O), .ARR_RDATA_I(ARR_RDATA_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
  sdram_ctrl_model sdram_ctrl_model_inst (.clk_i(MCLK_I), .cmd_o(CMD_I), .addr_o(ADDR_I),
    .dq_o(dq_m), .mask_o(BYTE_MASK_I));
  // Shared data pins: a byte the device drives wins over the controller.
  assign DQ_I = {DQ_OE_O[1] ? DQ_O[15:8] : dq_m[15:8], DQ_OE_O[0] ? DQ_O[7:0] : dq_m[7:0]};
  // Cell array: combinational read, byte-enabled write at the next edge.
  assign aidx = {ARR_REQ_O.bank, ARR_REQ_O.row[2:0], ARR_REQ_O.col};
  assign ARR_RDATA_I = mem[aidx];
  always @(posedge MCLK_I) begin
    if (ARR_REQ_O.wr === 1'b1 && ARR_REQ_O.be[0] === 1'b1) mem[aidx][7:0] <= ARR_REQ_O.wdata[7:0];
    if (ARR_REQ_O.wr === 1'b1 && ARR_REQ_O.be[1] === 1'b1) mem[aidx][15:8] <= ARR_REQ_O.wdata[15:8];
  end
  // Clock at 50 MHz.
  initial begin
    MCLK_I = 1'b0;
    forever #10 MCLK_I = ~MCLK_I;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One register bus cycle, held until waitrequest is seen low at an edge.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge MCLK_I);
    AVS_READ_I <= !w;
    AVS_WRITE_I <= w;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    // Waitrequest is sampled at each rising edge; the answer is taken at that edge.
    do begin
      @(posedge MCLK_I);
      t++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && t < 50);
    if (AVS_WAITREQUEST_O !== 1'b0) n_fail++;
    rv = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask
  task automatic set_mode(input logic [2:0] c, input logic i, input int l, input logic w);
    bl = (c == 3'h7) ? 256 : (1 << c);
    il = i;
    cl = l;
    wm = w;
    av(1'b1, REG_MODE, {22'h0, w, 2'h0, 3'(l), i, c});
  endtask
  // Column of beat k as the burst order prescribes.
  function automatic logic [7:0] col_at(input logic [7:0] s, input int k);
    logic [7:0] w;
    w = 8'(bl - 1);
    col_at = il ? ((s & ~w) | ((s ^ 8'(k)) & w)) : ((s & ~w) | ((s + 8'(k)) & w));
  endfunction
  task automatic act(input logic b, input logic [2:0] r);
    sdram_ctrl_model_inst.issue(CMD_ACT, {b, 8'h00, r}, 16'h0, 2'h0);
    row[b] = r;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [11:0] a);
    sdram_ctrl_model_inst.issue(op, a, 16'h0, 2'h0);
  endtask
  // Burst write of n words d, d+1, ...; the shadow copy follows the expected order.
  task automatic wr(input logic b, input logic [11:0] a, input int n, input logic [15:0] d,
    input logic [1:0] mk);
    logic [11:0] i;
    logic [15:0] dk;
    for (int k = 0; k < n; k++) begin
      dk = d + 16'(k);
      if (k == 0) sdram_ctrl_model_inst.issue(CMD_WR, {b, a[10:0]}, dk, mk);
      else sdram_ctrl_model_inst.put(3'h7, 12'h000, dk, mk);
      i = {b, row[b], col_at(a[7:0], k)};
      if (!mk[0]) sh[i][7:0] = dk[7:0];
      if (!mk[1]) sh[i][15:8] = dk[15:8];
    end
    if (n < bl && !wm) sdram_ctrl_model_inst.issue(CMD_BST, 12'h000, ~dk, 2'h0);
    else sdram_ctrl_model_inst.rel();
  endtask
  // Burst read of n words, mask held from the command edge on.
  task automatic rd(input logic b, input logic [11:0] a, input int n, input logic [1:0] mk);
    logic [1:0] eo;
    logic [15:0] bm;
    sdram_ctrl_model_inst.issue(CMD_RD, {b, a[10:0]}, 16'h0, mk);
    sdram_ctrl_model_inst.put(3'h7, 12'h000, 16'h0, mk);
    repeat (cl - 2) @(posedge MCLK_I);
    #1;
    chk(32'(DQ_OE_O), 32'h0);
    for (int k = 0; k < n; k++) begin
      @(posedge MCLK_I);
      #1;
      eo = (cl + k >= 2) ? ~mk : 2'h3;
      bm = {{8{eo[1]}}, {8{eo[0]}}};
      chk(32'(DQ_OE_O), 32'(eo));
      chk(32'(DQ_O & bm), 32'(sh[{b, row[b], col_at(a[7:0], k)}] & bm));
    end
    if (n == bl) begin
      @(posedge MCLK_I);
      #1;
      chk(32'(DQ_OE_O), 32'h0);
    end
    sdram_ctrl_model_inst.put(3'h7, 12'h000, 16'h0, 2'h0);
    repeat (3) @(posedge MCLK_I);
  endtask
  // Cuts a hung run short.
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'(i);
    for (int i = 0; i < 4096; i++) sh[i] = 16'(i);
    RST_I = 1'b1;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_ADDRESS_I = 4'h0;
    AVS_WRITEDATA_I = 32'h0;
    bl = 1;
    cl = 2;
    il = 1'b0;
    wm = 1'b0;
    repeat (4) @(posedge MCLK_I);
    RST_I <= 1'b0;
    av(1'b0, REG_MODE, 32'h0);
    chk(rv, 32'h20);
    av(1'b0, 4'hC, 32'h0);
    chk(rv, 32'h0);
    av(1'b1, REG_STATUS, 32'hFFFFFFFF);
    av(1'b0, REG_STATUS, 32'h0);
    chk(rv, 32'h0);
    $display("test reset done");
    act(1'b0, 3'h1);
    act(1'b1, 3'h2);
    av(1'b0, REG_STATUS, 32'h0);
    chk(rv & 32'h3, 32'h3);
    set_mode(3'h3, 1'b0, 2, 1'b0);
    wr(1'b0, 12'h003, 8, 16'hC000, 2'h0);
    rd(1'b0, 12'h003, 8, 2'h0);
    set_mode(3'h2, 1'b1, 2, 1'b0);
    wr(1'b1, 12'h021, 4, 16'hD000, 2'h2);
    rd(1'b1, 12'h021, 4, 2'h0);
    $display("test burst write done");
    for (int i = 1; i < 4; i++) begin
      set_mode(3'(i), 1'b1, 3, 1'b0);
      rd(1'b0, 12'h305, bl, 2'h1);
      set_mode(3'(i), 1'b0, 2, 1'b0);
      rd(1'b1, 12'h306, bl, 2'h2);
    end
    $display("test burst order done");
    set_mode(3'h3, 1'b0, 2, 1'b1);
    wr(1'b0, 12'h040, 1, 16'hE000, 2'h0);
    set_mode(3'h7, 1'b0, 2, 1'b1);
    wr(1'b0, 12'h044, 1, 16'hE100, 2'h0);
    set_mode(3'h3, 1'b0, 2, 1'b0);
    rd(1'b0, 12'h040, 8, 2'h0);
    $display("test single write done");
    set_mode(3'h7, 1'b0, 2, 1'b0);
    rd(1'b0, 12'h0FE, 4, 2'h0);
    cmd(CMD_BST, 12'h000);
    // Let the read drain so the device no longer drives the data pins.
    repeat (2) @(posedge MCLK_I);
    wr(1'b1, 12'h0FF, 3, 16'hF000, 2'h0);
    rd(1'b1, 12'h0FF, 3, 2'h0);
    cmd(CMD_BST, 12'h000);
    $display("test full page done");
    set_mode(3'h2, 1'b0, 2, 1'b0);
    rd(1'b0, 12'h401, 4, 2'h0);
    repeat (TRP) @(posedge MCLK_I);
    act(1'b0, 3'h4);
    rd(1'b0, 12'h001, 4, 2'h0);
    cmd(CMD_ACT, 12'h006);
    rd(1'b0, 12'h002, 4, 2'h0);
    set_mode(3'h7, 1'b0, 2, 1'b0);
    rd(1'b0, 12'h4F0, 2, 2'h0);
    cmd(CMD_BST, 12'h000);
    repeat (TRP + 2) @(posedge MCLK_I);
    cmd(CMD_ACT, 12'h007);
    set_mode(3'h2, 1'b0, 2, 1'b0);
    rd(1'b0, 12'h003, 4, 2'h0);
    $display("test auto precharge done");
    cmd(CMD_PRE, 12'h800);
    repeat (TRP + 3) @(posedge MCLK_I);
    av(1'b0, REG_STATUS, 32'h0);
    chk(rv & 32'h3, 32'h1);
    cmd(CMD_PRE, 12'h400);
    repeat (TRP + 3) @(posedge MCLK_I);
    av(1'b0, REG_STATUS, 32'h0);
    chk(rv & 32'h3, 32'h0);
    // Mode set command on the pins, with both banks idle.
    cmd(CMD_MRS, 12'h023);
    sdram_ctrl_model_inst.rel();
    av(1'b0, REG_MODE, 32'h0);
    chk(rv, 32'h23);
    $display("test precharge done");
    give_verdict();
  end
endmodule
`default_nettype wire
